/* File: servo_reference_mode_select.sv */
// top: settings registers, limit gating, pulse inhibit, jog clamp
// Overview of operation
// - analog torque limit only in mode 9
// - forward limit caps forward torque at reference
// - reverse limit caps reverse torque at reference
// - limit inputs active low, high runs uncapped
// - external torque limit enable bit, default 0
// - no torque control during analog limiting
// - torque gain setting 10 to 100, default 30
// - inhibit stops pulse counting, holds position
// - mode 11 input switches pulse inhibit
// - modes 0,1 input selects P or PI
// - modes 3-6 input switches rotation direction
// - modes 7-9 input switches paired modes
// - mode 10 input switches zero clamp
// - jog speed setting 0 to 2500, default 500
// - jog speed clamped to maximum speed
// - jog speed used for operator panel runs
// - proportional-control input active low
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`include "servo_sel_defs.svh"
module servo_reference_mode_select
	import servo_sel_pkg::*;
#(
	parameter int TRQ_W = 16,
	parameter int CNT_W = 32
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic fwd_limit_in_n_i,
	input wire logic rev_limit_in_n_i,
	input wire logic prop_ctrl_in_n_i,
	input wire logic pulse_i,
	input wire logic pulse_dir_i,
	input wire logic panel_jog_i,
	input wire logic signed [TRQ_W-1:0] torque_ref_i,
	input wire logic signed [TRQ_W-1:0] torque_demand_i,
	output logic signed [TRQ_W-1:0] torque_cmd_o,
	output logic [2:0] loop_sel_o,
	output logic p_only_o,
	output logic dir_rev_o,
	output logic zclamp_o,
	output logic inhibit_o,
	output logic step_o,
	output logic [11:0] panel_speed_o,
	output logic [CNT_W-1:0] pulse_count_o
);
	initial begin
		if (TRQ_W < 2 || TRQ_W > 32) $error("TRQ_W must be 2..32");
		if (CNT_W < 2 || CNT_W > 32) $error("CNT_W must be 2..32");
	end

	typedef struct packed {
		bus_state_e bus;
		logic [7:0] addr;
		logic wr;
		logic ext_tl_en;
		logic torque_ff_en;
		logic [3:0] control_mode_sel;
		logic [6:0] torque_ref_gain;
		speed_t jog_speed_set;
		speed_t max_speed;
		logic [31:0] rdata;
		logic ready;
		logic resp;
		logic pulse_d;
		logic [CNT_W-1:0] count;
		logic signed [TRQ_W-1:0] trq;
		logic [2:0] loop_sel;
		logic p_only;
		logic dir_rev;
		logic zclamp;
		logic inhibit;
		logic step;
		speed_t panel_speed;
	} state_s;
	state_s r;
	state_s next_r;

	logic [4:0] pins_raw;
	logic [4:0] pins;
	logic fwd_act;
	logic rev_act;
	logic pcon_act;
	loop_e dec_loop;
	logic dec_p_only;
	logic dec_dir_rev;
	logic dec_zclamp;
	logic dec_inhibit;
	logic dec_step;
	logic dec_analog_tl;

	assign pins_raw = {panel_jog_i, pulse_dir_i, pulse_i, rev_limit_in_n_i, fwd_limit_in_n_i};
	// limits reset inactive (high), pulse, direction and jog low

	pin_sync #(
		.WIDTH(5),
		.INIT(5'h03)
	) u_sync (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.d_i(pins_raw),
		.q_o(pins)
	);

	logic [0:0] pcon_sync;
	pin_sync #(
		.WIDTH(1),
		.INIT(1'b1)
	) u_sync_pcon (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.d_i(prop_ctrl_in_n_i),
		.q_o(pcon_sync)
	);

	assign fwd_act = ~pins[0];
	assign rev_act = ~pins[1];
	assign pcon_act = ~pcon_sync[0];

	mode_decode u_dec (
		.mode_i(r.control_mode_sel),
		.pcon_act_i(pcon_act),
		.ext_tl_en_i(r.ext_tl_en),
		.loop_o(dec_loop),
		.p_only_o(dec_p_only),
		.dir_rev_o(dec_dir_rev),
		.zclamp_o(dec_zclamp),
		.inhibit_o(dec_inhibit),
		.step_o(dec_step),
		.analog_tl_o(dec_analog_tl)
	);

	function automatic logic signed [TRQ_W-1:0] abs_of(input logic signed [TRQ_W-1:0] v);
		if (!v[TRQ_W-1]) begin
			abs_of = v;
		end else if (v == {1'b1, {(TRQ_W-1){1'b0}}}) begin
			// most negative reference saturates instead of staying negative
			abs_of = {1'b0, {(TRQ_W-1){1'b1}}};
		end else begin
			abs_of = -v;
		end
	endfunction

	// speeds in r/min: upper bits clear, no more than the ceiling
	function automatic logic speed_ok(input logic [31:0] w);
		speed_ok = w[11:0] <= `JOG_MAX && w[31:12] == '0;
	endfunction

	function automatic speed_t clamp_speed(input speed_t v, input speed_t lim);
		clamp_speed = (v > lim) ? lim : v;
	endfunction

	logic signed [TRQ_W-1:0] lim_mag;
	logic signed [TRQ_W-1:0] trq_capped;
	always_comb begin
		lim_mag = abs_of(torque_ref_i);
		trq_capped = torque_demand_i;
		// a cap only pulls demand toward the limit, never flips its sign
		if (dec_analog_tl) begin
			if (fwd_act && !torque_demand_i[TRQ_W-1] && torque_demand_i > lim_mag) begin
				trq_capped = lim_mag;
			end
			if (rev_act && torque_demand_i[TRQ_W-1] && torque_demand_i < -lim_mag) begin
				trq_capped = -lim_mag;
			end
		end
	end

	logic addr_ok;
	always_comb begin
		next_r = r;
		addr_ok = haddr_i[31:8] == '0 && hsize_i == `HSIZE_WORD;
		// ce low: every field keeps its value
		if (ce_i) begin
			next_r.bus = BUS_IDLE;
			// zero wait states, response always okay
			next_r.ready = 1'b1;
			next_r.resp = 1'b0;
			if (r.bus == BUS_DATA && r.wr) begin
				case (r.addr)
					`ADDR_CTRL: begin
						next_r.ext_tl_en = hwdata_i[`CTRL_EXT_TL_BIT];
						next_r.torque_ff_en = hwdata_i[`CTRL_FF_BIT];
						next_r.control_mode_sel = hwdata_i[`CTRL_MODE_LSB +: `CTRL_MODE_W];
					end
					`ADDR_TRQ_GAIN: begin
						if (hwdata_i[6:0] >= `GAIN_MIN && hwdata_i[6:0] <= `GAIN_MAX && hwdata_i[31:7] == '0) begin
							next_r.torque_ref_gain = hwdata_i[6:0];
						end
					end
					`ADDR_JOG: begin
						if (speed_ok(hwdata_i)) begin
							next_r.jog_speed_set = hwdata_i[11:0];
						end
					end
					`ADDR_MAX_SPEED: begin
						if (speed_ok(hwdata_i)) begin
							next_r.max_speed = hwdata_i[11:0];
						end
					end
					default: begin
						next_r.max_speed = r.max_speed;
					end
				endcase
			end
			if (hsel_i && hready_i && htrans_i[1]) begin
				next_r.bus = BUS_DATA;
				next_r.addr = haddr_i[7:0];
				next_r.wr = hwrite_i && addr_ok;
				next_r.rdata = '0;
				// settings come from next_r so a write in its data phase is seen at once
				if (!hwrite_i && addr_ok) begin
					case (haddr_i[7:0])
						`ADDR_CTRL: begin
							next_r.rdata = {24'h0, next_r.control_mode_sel, 2'b00, next_r.torque_ff_en,
								next_r.ext_tl_en};
						end
						`ADDR_TRQ_GAIN: begin
							next_r.rdata = {25'h0, next_r.torque_ref_gain};
						end
						`ADDR_JOG: begin
							next_r.rdata = {20'h0, next_r.jog_speed_set};
						end
						`ADDR_MAX_SPEED: begin
							next_r.rdata = {20'h0, next_r.max_speed};
						end
						`ADDR_STATUS: begin
							next_r.rdata = {20'h0, pcon_act, rev_act, fwd_act, r.step, r.inhibit,
								r.zclamp, r.dir_rev, r.p_only, 1'b0, r.loop_sel};
						end
						`ADDR_PULSE_CNT: begin
							next_r.rdata = 32'(r.count);
						end
						`ADDR_TRQ_OUT: begin
							next_r.rdata = 32'(signed'(r.trq));
						end
						default: begin
							next_r.rdata = '0;
						end
					endcase
				end
			end
			// rising edge of the synced pulse pin
			next_r.pulse_d = pins[2];
			if (pins[2] && !r.pulse_d && dec_loop == LOOP_POSITION && !dec_inhibit) begin
				next_r.count = pins[3] ? r.count - 1'b1 : r.count + 1'b1;
			end
			// edges during inhibit are dropped, count holds the locked position
			next_r.trq = trq_capped;
			next_r.loop_sel = dec_loop;
			next_r.p_only = dec_p_only;
			next_r.dir_rev = dec_dir_rev;
			next_r.zclamp = dec_zclamp;
			next_r.inhibit = dec_inhibit;
			next_r.step = dec_step;
			next_r.panel_speed = pins[4] ? clamp_speed(r.jog_speed_set, r.max_speed) : '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			r <= '0;
			r.bus <= BUS_IDLE;
			r.ready <= 1'b1;
			r.ext_tl_en <= `RST_EXT_TL;
			r.torque_ff_en <= `RST_FF;
			r.control_mode_sel <= `RST_MODE;
			r.torque_ref_gain <= `RST_GAIN;
			r.jog_speed_set <= `RST_JOG;
			r.max_speed <= `RST_MAX_SPEED;
			r.loop_sel <= LOOP_SPEED;
		end else begin
			r <= next_r;
		end
	end

	assign hrdata_o = r.rdata;
	assign hreadyout_o = r.ready;
	assign hresp_o = r.resp;
	assign torque_cmd_o = r.trq;
	assign loop_sel_o = r.loop_sel;
	assign p_only_o = r.p_only;
	assign dir_rev_o = r.dir_rev;
	assign zclamp_o = r.zclamp;
	assign inhibit_o = r.inhibit;
	assign step_o = r.step;
	assign panel_speed_o = r.panel_speed;
	assign pulse_count_o = r.count;
endmodule

/* File: servo_sel_defs.svh */
// constants for the servo reference mode select block
`ifndef SERVO_SEL_DEFS_SVH
`define SERVO_SEL_DEFS_SVH
`define ADDR_CTRL 8'h00
`define ADDR_TRQ_GAIN 8'h04
`define ADDR_JOG 8'h08
`define ADDR_MAX_SPEED 8'h0c
`define ADDR_STATUS 8'h10
`define ADDR_PULSE_CNT 8'h14
`define ADDR_TRQ_OUT 8'h18
`define HSIZE_WORD 3'h2
`define CTRL_EXT_TL_BIT 0
`define CTRL_FF_BIT 1
`define CTRL_MODE_LSB 4
`define CTRL_MODE_W 4
`define RST_EXT_TL 1'b0
`define RST_FF 1'b0
`define RST_MODE 4'h0
`define RST_GAIN 7'd30
`define GAIN_MIN 7'd10
`define GAIN_MAX 7'd100
`define RST_JOG 12'd500
`define JOG_MAX 12'd2500
`define RST_MAX_SPEED 12'd2500
`define MODE_SPD 4'd0
`define MODE_POS 4'd1
`define MODE_TRQ 4'd2
`define MODE_CONTACT_LO 4'd3
`define MODE_CONTACT_HI 4'd6
`define MODE_POS_SPD 4'd7
`define MODE_POS_TRQ 4'd8
`define MODE_TRQ_SPD 4'd9
`define MODE_ZCLAMP 4'd10
`define MODE_INHIBIT 4'd11
`define MODE_PARAM_POS 4'd12
`endif

/* File: servo_sel_pkg.sv */
// types for the servo reference mode select block
package servo_sel_pkg;
	typedef enum logic [2:0] {
		LOOP_SPEED = 3'b001,
		LOOP_POSITION = 3'b010,
		LOOP_TORQUE = 3'b100
	} loop_e;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_DATA = 2'b10
	} bus_state_e;
	typedef logic [11:0] speed_t;
endpackage

/* File: pin_sync.sv */
// two-stage synchroniser for pin inputs
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '1
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} sync_s;
	sync_s r;
	sync_s next_r;
	initial begin
		if (WIDTH < 1) $error("pin_sync width must be positive");
	end
	always_comb begin
		next_r = r;
		if (ce_i) begin
			next_r.s1 = d_i;
			next_r.s2 = r.s1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			r <= {INIT, INIT};
		end else begin
			r <= next_r;
		end
	end
	assign q_o = r.s2;
endmodule

/* File: mode_decode.sv */
// decodes control mode and proportional-control input meaning
`include "servo_sel_defs.svh"
module mode_decode
	import servo_sel_pkg::*;
(
	input wire logic [3:0] mode_i,
	input wire logic pcon_act_i,
	input wire logic ext_tl_en_i,
	output loop_e loop_o,
	output logic p_only_o,
	output logic dir_rev_o,
	output logic zclamp_o,
	output logic inhibit_o,
	output logic step_o,
	output logic analog_tl_o
);
	always_comb begin
		loop_o = LOOP_SPEED;
		p_only_o = 1'b0;
		dir_rev_o = 1'b0;
		zclamp_o = 1'b0;
		inhibit_o = 1'b0;
		step_o = 1'b0;
		analog_tl_o = 1'b0;
		case (mode_i)
			`MODE_SPD: begin
				p_only_o = pcon_act_i;
			end
			`MODE_POS: begin
				loop_o = LOOP_POSITION;
				p_only_o = pcon_act_i;
			end
			`MODE_TRQ: begin
				loop_o = LOOP_TORQUE;
			end
			`MODE_POS_SPD: begin
				loop_o = pcon_act_i ? LOOP_SPEED : LOOP_POSITION;
			end
			`MODE_POS_TRQ: begin
				loop_o = pcon_act_i ? LOOP_TORQUE : LOOP_POSITION;
			end
			`MODE_TRQ_SPD: begin
				// analog limit takes the torque channel, so torque loop is withheld
				analog_tl_o = ext_tl_en_i;
				if (ext_tl_en_i) begin
					loop_o = LOOP_SPEED;
				end else begin
					loop_o = pcon_act_i ? LOOP_SPEED : LOOP_TORQUE;
				end
			end
			`MODE_ZCLAMP: begin
				zclamp_o = pcon_act_i;
			end
			`MODE_INHIBIT: begin
				loop_o = LOOP_POSITION;
				inhibit_o = pcon_act_i;
			end
			`MODE_PARAM_POS: begin
				loop_o = LOOP_POSITION;
				step_o = pcon_act_i;
			end
			default: begin
				if (mode_i >= `MODE_CONTACT_LO && mode_i <= `MODE_CONTACT_HI) begin
					dir_rev_o = pcon_act_i;
				end else begin
					loop_o = LOOP_SPEED;
				end
			end
		endcase
	end
endmodule

/* File: sel_checker.sv */
// assertions on the ports of the servo reference mode select block
module sel_checker #(
	parameter int TRQ_W = 16,
	parameter int CNT_W = 32
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic fwd_limit_in_n_i,
	input wire logic rev_limit_in_n_i,
	input wire logic panel_jog_i,
	input wire logic signed [TRQ_W-1:0] torque_ref_i,
	input wire logic signed [TRQ_W-1:0] torque_demand_i,
	input wire logic signed [TRQ_W-1:0] torque_cmd_o,
	input wire logic [2:0] loop_sel_o,
	input wire logic p_only_o,
	input wire logic dir_rev_o,
	input wire logic zclamp_o,
	input wire logic inhibit_o,
	input wire logic step_o,
	input wire logic [11:0] panel_speed_o,
	input wire logic [CNT_W-1:0] pulse_count_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic signed [TRQ_W-1:0] mag;
	assign mag = torque_ref_i < 0 ? -torque_ref_i : torque_ref_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	loop_onehot_a: assert property ($onehot(loop_sel_o))
		else $error("loop select not one-hot");
	one_meaning_a: assert property ($onehot0({p_only_o, dir_rev_o, zclamp_o, inhibit_o, step_o}))
		else $error("more than one meaning of the prop input");
	no_cap_a: assert property ((fwd_limit_in_n_i && rev_limit_in_n_i) [*4] |-> torque_cmd_o == $past(torque_demand_i))
		else $error("torque capped with both limits idle");
	cap_value_a: assert property (!$past(srst_i) |-> torque_cmd_o == $past(torque_demand_i) || torque_cmd_o == $past(mag)
		|| torque_cmd_o == -$past(mag))
		else $error("torque neither demand nor limit value");
	cap_sign_a: assert property ($past(torque_demand_i) >= 0 |-> torque_cmd_o >= 0
		&& torque_cmd_o <= $past(torque_demand_i))
		else $error("forward torque raised or flipped");
	jog_idle_a: assert property (!panel_jog_i [*4] |=> panel_speed_o == '0)
		else $error("panel speed without jog request");
	count_step_a: assert property (pulse_count_o == $past(pulse_count_o)
		|| pulse_count_o == $past(pulse_count_o) + 1'b1 || pulse_count_o == $past(pulse_count_o) - 1'b1)
		else $error("pulse count jumped");
	inhibit_hold_a: assert property (inhibit_o [*3] |-> $stable(pulse_count_o))
		else $error("pulse counted while inhibited");
endmodule
bind servo_reference_mode_select sel_checker #(.TRQ_W(TRQ_W), .CNT_W(CNT_W)) chk (.clk_i, .srst_i,
	.fwd_limit_in_n_i, .rev_limit_in_n_i, .panel_jog_i, .torque_ref_i, .torque_demand_i, .torque_cmd_o,
	.loop_sel_o, .p_only_o, .dir_rev_o, .zclamp_o, .inhibit_o, .step_o, .panel_speed_o, .pulse_count_o);

/* File: host_model.sv */
// host controller model: reference pulse train and torque limit channel
module host_model (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [3:0] n_i,
	input wire logic signed [15:0] lim_i,
	output logic pulse_o,
	output logic busy_o,
	output logic signed [15:0] torque_ref_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [6:0] cnt = '0;
	assign torque_ref_o = lim_i;
	assign busy_o = cnt != 0;
	// four high, four low per pulse so the pin syncs see each one
	assign pulse_o = cnt[2];
	always @(posedge clk_i) cnt <= go_i ? {n_i, 3'b000} : cnt - 7'(busy_o);
endmodule

/* File: tb_servo_reference_mode_select.sv */
// self-checking bench for the servo reference mode select block
`include "servo_sel_defs.svh"
module tb_servo_reference_mode_select;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, srst_i = 1, hsel = 0, hwrite = 0, fwd_n = 1, rev_n = 1, prop_n = 1, jog = 0, go = 0;
	logic ce = 1, pdir = 0;
	logic [1:0] htrans = 0;
	logic [7:0] haddr = 0;
	logic [3:0] n = 0;
	logic [31:0] hwdata = 0, rd, hrdata, cnt;
	logic signed [15:0] lim = 0, dem = 0, tcmd, tref;
	logic hrdy, hresp, pulse, busy, p_only, dir_rev, zcl, inh, step;
	logic [2:0] loop;
	logic [11:0] pspd;
	int errors = 0, samples_checked = 0;
	// {p_only, dir_rev, zclamp, inhibit, step, loop} with prop active; loop 0 = not checked
	logic [7:0] rows [16] = '{8'h81, 8'h82, 8'h04, 8'h40, 8'h40, 8'h40, 8'h40, 8'h01, 8'h04, 8'h01, 8'h21,
		8'h12, 8'h08, 8'h00, 8'h00, 8'h00};
	always #10 clk_i = ~clk_i;
	servo_reference_mode_select #(.TRQ_W(16), .CNT_W(32)) dut (.clk_i, .srst_i, .ce_i(ce), .hsel_i(hsel),
		.haddr_i({24'h0, haddr}), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
		.hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .fwd_limit_in_n_i(fwd_n),
		.rev_limit_in_n_i(rev_n), .prop_ctrl_in_n_i(prop_n), .pulse_i(pulse), .pulse_dir_i(pdir),
		.panel_jog_i(jog), .torque_ref_i(tref), .torque_demand_i(dem), .torque_cmd_o(tcmd), .loop_sel_o(loop),
		.p_only_o(p_only), .dir_rev_o(dir_rev), .zclamp_o(zcl), .inhibit_o(inh), .step_o(step),
		.panel_speed_o(pspd), .pulse_count_o(cnt));
	host_model hm (.clk_i, .go_i(go), .n_i(n), .lim_i(lim), .pulse_o(pulse), .busy_o(busy), .torque_ref_o(tref));
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		hsel <= 1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk_i); while (hrdy !== 1'b1);
		hsel <= 0;
		htrans <= 0;
		hwdata <= d;
		do @(posedge clk_i); while (hrdy !== 1'b1);
		rd = hrdata;
	endtask
	task automatic settle;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic wrd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		xfer(1, a, d);
		xfer(0, a, 0);
		chk("reg", e, rd);
		chk("resp", 0, hresp);
	endtask
	task automatic send(input logic [3:0] k);
		go <= 1;
		n <= k;
		@(posedge clk_i);
		go <= 0;
		do @(posedge clk_i); while (busy === 1'b1);
		settle();
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		report_and_stop();
	end
	initial begin
		repeat (16) @(posedge clk_i);
		srst_i <= 0;
		prop_n <= 0;
		for (int m = 0; m < 16; m++) begin
			xfer(1, `ADDR_CTRL, 32'(m) << 4);
			settle();
			chk("flags", rows[m][7:3], {p_only, dir_rev, zcl, inh, step});
			if (rows[m][2:0] != 0)
				chk("loop", rows[m][2:0], loop);
		end
		$display("mode table done");
		xfer(1, `ADDR_CTRL, 32'hb0);
		prop_n <= 1;
		settle();
		chk("inhibit", 0, inh);
		xfer(1, `ADDR_CTRL, 32'h10);
		send(5);
		chk("count", 5, cnt);
		xfer(1, `ADDR_CTRL, 32'hb0);
		prop_n <= 0;
		settle();
		send(3);
		chk("count", 5, cnt);
		prop_n <= 1;
		settle();
		send(2);
		chk("count", 7, cnt);
		pdir <= 1;
		send(2);
		chk("count", 5, cnt);
		ce <= 0;
		send(3);
		ce <= 1;
		settle();
		chk("count", 5, cnt);
		xfer(0, `ADDR_PULSE_CNT, 0);
		chk("reg", 5, rd);
		$display("pulse inhibit done");
		xfer(1, `ADDR_CTRL, 32'h91);
		lim <= 100;
		dem <= 500;
		fwd_n <= 0;
		settle();
		chk("torque", lim, tcmd);
		chk("loop", 3'b001, loop);
		dem <= -500;
		settle();
		chk("torque", dem, tcmd);
		rev_n <= 0;
		settle();
		chk("torque", -lim, tcmd);
		xfer(1, `ADDR_CTRL, 32'h90);
		settle();
		chk("torque", dem, tcmd);
		xfer(1, `ADDR_CTRL, 32'h01);
		settle();
		chk("torque", dem, tcmd);
		$display("torque limit done");
		wrd(`ADDR_TRQ_GAIN, 9, 30);
		wrd(`ADDR_TRQ_GAIN, 101, 30);
		wrd(`ADDR_TRQ_GAIN, 10, 10);
		wrd(`ADDR_TRQ_GAIN, 100, 100);
		wrd(`ADDR_MAX_SPEED, 1000, 1000);
		wrd(`ADDR_JOG, 2500, 2500);
		wrd(`ADDR_JOG, 2501, 2500);
		jog <= 1;
		settle();
		chk("panel", 1000, pspd);
		xfer(1, `ADDR_MAX_SPEED, 2500);
		settle();
		chk("panel", 2500, pspd);
		xfer(1, `ADDR_JOG, 300);
		settle();
		chk("panel", 300, pspd);
		jog <= 0;
		settle();
		chk("panel", 0, pspd);
		$display("settings done");
		srst_i <= 1;
		repeat (3) @(posedge clk_i);
		srst_i <= 0;
		chk("loop", 3'b001, loop);
		chk("count", 0, cnt);
		xfer(0, `ADDR_CTRL, 0);
		chk("reg", 0, rd);
		xfer(0, `ADDR_TRQ_GAIN, 0);
		chk("reg", 30, rd);
		xfer(0, `ADDR_JOG, 0);
		chk("reg", 500, rd);
		xfer(0, `ADDR_MAX_SPEED, 0);
		chk("reg", 2500, rd);
		xfer(0, 8'h1c, 0);
		chk("reg", 0, rd);
		xfer(0, `ADDR_STATUS, 0);
		chk("reg", 32'h601, rd);
		xfer(0, `ADDR_TRQ_OUT, 0);
		chk("reg", 32'hfffffe0c, rd);
		$display("reset values done");
		report_and_stop();
	end
endmodule
